// *** core/cfg_pkg.sv ***
// constants and carrier types for the sensor configuration register
package cfg_pkg;

	// ****************************************
	// register layout
	// ****************************************
	localparam logic [15:0] CFG_RESET = 16'h60A0;
	localparam logic [15:0] CFG_WR_MASK = 16'h1FD0;
	localparam logic [15:0] CFG_HI_LANE = 16'hFF00;
	localparam logic [15:0] CFG_LO_LANE = 16'h00FF;
	localparam int unsigned IDLE_BIT = 15;
	localparam int unsigned RES_HI_BIT = 14;
	localparam int unsigned RES_LO_BIT = 13;
	localparam int unsigned FAULT_HI_BIT = 12;
	localparam int unsigned FAULT_LO_BIT = 11;
	localparam int unsigned POL_BIT = 10;
	localparam int unsigned MODE_BIT = 9;
	localparam int unsigned SHDN_BIT = 8;
	localparam int unsigned RATE_HI_BIT = 7;
	localparam int unsigned RATE_LO_BIT = 6;
	localparam int unsigned CMP_BIT = 5;
	localparam int unsigned WIDE_BIT = 4;
	localparam logic [1:0] RES_FIXED = 2'h3;
	localparam logic [3:0] LOW_NIBBLE_ZERO = 4'h0;

	// ****************************************
	// link codes
	// ****************************************
	localparam logic [7:0] PTR_CONFIG = 8'h01;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [7:0] GCALL_RESET_CODE = 8'h06;

	// ****************************************
	// fault counts
	// ****************************************
	localparam logic [2:0] FAULTS_CODE0 = 3'h1;
	localparam logic [2:0] FAULTS_CODE1 = 3'h2;
	localparam logic [2:0] FAULTS_CODE2 = 3'h4;
	localparam logic [2:0] FAULTS_CODE3 = 3'h6;

	// ****************************************
	// conversion rate timing
	// ****************************************
	localparam longint unsigned CLK_HZ = 50_000_000;
	localparam longint unsigned RATE0_MS = 4000;
	localparam longint unsigned RATE1_MS = 1000;
	localparam longint unsigned RATE2_MS = 250;
	localparam longint unsigned RATE3_MS = 125;
	localparam int unsigned RATE0_CYC = int'(RATE0_MS * CLK_HZ / 1000);
	localparam int unsigned RATE1_CYC = int'(RATE1_MS * CLK_HZ / 1000);
	localparam int unsigned RATE2_CYC = int'(RATE2_MS * CLK_HZ / 1000);
	localparam int unsigned RATE3_CYC = int'(RATE3_MS * CLK_HZ / 1000);
	localparam int unsigned TIMER_W = 28;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic [15:0] data;
		logic [1:0] lanes;
	} wr_word_t;

	typedef struct packed {
		logic busy;
		logic done;
		logic above_high;
		logic below_low;
	} sense_t;

endpackage

// *** core/fault_filter.sv ***
// consecutive-fault filter behind the comparator status bit
module fault_filter (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic clear,
	// samples
	input wire logic sample,
	input wire logic above_high,
	input wire logic below_low,
	// settings
	input wire logic [1:0] fault_sel,
	input wire logic active_level,
	// results
	output logic over_temp,
	output logic comparator_flag
);

	typedef struct packed {
		logic active;
		logic [2:0] cnt;
		logic flag;
	} filt_state_t;

	filt_state_t s_q;
	filt_state_t s_d;

	function automatic logic [2:0] faults_needed(input logic [1:0] sel);
		case (sel)
			2'h0: faults_needed = cfg_pkg::FAULTS_CODE0;
			2'h1: faults_needed = cfg_pkg::FAULTS_CODE1;
			2'h2: faults_needed = cfg_pkg::FAULTS_CODE2;
			default: faults_needed = cfg_pkg::FAULTS_CODE3;
		endcase
	endfunction

	always_comb begin
		logic hit;
		logic [2:0] next_cnt;
		hit = 1'b0;
		next_cnt = 3'h0;
		s_d = s_q;
		if (sample) begin
			// R10: consecutive limit faults
			hit = s_q.active ? below_low : above_high;
			next_cnt = s_q.cnt + 3'h1;
			if (!hit) begin
				s_d.cnt = 3'h0;
			end else if (next_cnt >= faults_needed(fault_sel)) begin
				s_d.active = ~s_q.active;
				s_d.cnt = 3'h0;
			end else begin
				s_d.cnt = next_cnt;
			end
		end
		if (clear) begin
			s_d.active = 1'b0;
			s_d.cnt = 3'h0;
		end
		// R11: level follows polarity
		s_d.flag = ~(s_d.active ^ active_level);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '{active: 1'b0, cnt: 3'h0,
				flag: cfg_pkg::CFG_RESET[cfg_pkg::CMP_BIT]};
		end else begin
			s_q <= s_d;
		end
	end

	assign over_temp = s_q.active;
	assign comparator_flag = s_q.flag;

endmodule // fault_filter

// *** core/link_port.sv ***
// link-clock side: pointer, byte order and word crossings
module link_port (
	// link clock and raw reset
	input wire logic clk,
	input wire logic rst_raw,
	// byte strobes from the protocol engine
	input wire logic frame_start,
	input wire logic ptr_wr,
	input wire logic data_wr,
	input wire logic gcall_wr,
	input wire logic rd_req,
	input wire logic [7:0] wr_byte,
	// read answer
	output logic [7:0] rd_byte,
	output logic rd_hit,
	// crossings to and from the system clock
	output logic wr_req_tgl,
	output cfg_pkg::wr_word_t wr_word,
	input wire logic wr_ack_tgl,
	output logic gc_tgl,
	input wire logic snap_req_tgl,
	input wire logic [15:0] snap_word,
	output logic snap_ack_tgl
);

	typedef struct packed {
		logic rst_s1;
		logic rst_s2;
		logic [7:0] ptr;
		logic idx;
		cfg_pkg::wr_word_t pend;
		cfg_pkg::wr_word_t out;
		logic req;
		logic ack_s1;
		logic ack_s2;
		logic gc;
		logic sreq_s1;
		logic sreq_s2;
		logic sack;
		logic [15:0] shadow;
		logic [7:0] rd_byte;
		logic rd_hit;
	} link_state_t;

	link_state_t s_q;
	link_state_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.rst_s1 = rst_raw;
		s_d.rst_s2 = s_q.rst_s1;
		s_d.ack_s1 = wr_ack_tgl;
		s_d.ack_s2 = s_q.ack_s1;
		s_d.sreq_s1 = snap_req_tgl;
		s_d.sreq_s2 = s_q.sreq_s1;
		// word stays stable until the toggle is echoed back
		if (s_q.sreq_s2 != s_q.sack) begin
			s_d.shadow = snap_word;
			s_d.sack = s_q.sreq_s2;
		end
		if (s_q.req == s_q.ack_s2 && s_q.pend.lanes != 2'h0) begin
			s_d.out = s_q.pend;
			s_d.req = ~s_q.req;
			s_d.pend.lanes = 2'h0;
		end
		if (frame_start) begin
			s_d.idx = 1'b0;
		end
		if (ptr_wr) begin
			// R14: pointer selects register
			s_d.ptr = wr_byte;
			s_d.idx = 1'b0;
		end else if (data_wr && s_q.ptr == cfg_pkg::PTR_CONFIG) begin
			// R2: high byte first
			if (!s_q.idx) begin
				s_d.pend.data[15:8] = wr_byte;
				s_d.pend.lanes[1] = 1'b1;
			end else begin
				s_d.pend.data[7:0] = wr_byte;
				s_d.pend.lanes[0] = 1'b1;
			end
			s_d.idx = ~s_q.idx;
		end else if (rd_req) begin
			s_d.idx = ~s_q.idx;
		end
		// R15: general call reset
		if (gcall_wr && wr_byte == cfg_pkg::GCALL_RESET_CODE) begin
			s_d.gc = ~s_q.gc;
			s_d.ptr = cfg_pkg::PTR_RESET;
			s_d.pend.lanes = 2'h0;
			s_d.idx = 1'b0;
		end
		// R2: read order msb, lsb
		s_d.rd_byte = s_d.idx ? s_d.shadow[7:0] : s_d.shadow[15:8];
		s_d.rd_hit = (s_d.ptr == cfg_pkg::PTR_CONFIG);
	end

	always_ff @(posedge clk) begin
		if (s_q.rst_s2) begin
			s_q <= '{rst_s1: s_d.rst_s1, rst_s2: s_d.rst_s2,
				ptr: cfg_pkg::PTR_RESET, idx: 1'b0,
				pend: '0, out: '0, req: 1'b0,
				ack_s1: 1'b0, ack_s2: 1'b0, gc: 1'b0,
				sreq_s1: 1'b0, sreq_s2: 1'b0, sack: 1'b0,
				shadow: cfg_pkg::CFG_RESET,
				rd_byte: cfg_pkg::CFG_RESET[15:8], rd_hit: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign rd_byte = s_q.rd_byte;
	assign rd_hit = s_q.rd_hit;
	assign wr_req_tgl = s_q.req;
	assign wr_word = s_q.out;
	assign gc_tgl = s_q.gc;
	assign snap_ack_tgl = s_q.sack;

endmodule // link_port

// *** core/temp_sensor_config.sv ***
// configuration register of the temperature sensor, system clock side
//
// Notes on behaviour
// R1: one 16-bit read/write register built from high and low byte.
// R2: serial transfers move the high byte first, then the low byte.
// R3: high bit 7 reads 1 when idle, 0 while converting; resets 0.
// R4: high bits 6:5 always read 11, fixed 12-bit resolution.
// R5: high bits 4:3 pick 1, 2, 4 or 6 consecutive faults; default 00.
// R6: high bit 2 sets alert active level: 1 high, 0 low.
// R7: high bit 1 selects interrupt mode when 1, comparator when 0.
// R8: high bit 0 selects shutdown when 1, continuous conversion when 0.
// R9: low bits 7:6 pick 0.25, 1, 4 or 8 Hz; reset 10.
// R10: low bit 5 reads 1 until high limit faults, then 0 until low.
// R11: polarity 1 inverts the comparator status bit.
// R12: mode bit never changes how the comparator status behaves.
// R13: low bit 4 selects 13-bit format when 1, 12-bit when 0.
// R14: pointer byte 01 with upper six bits zero selects this register.
// R15: general call 06h restores defaults and aborts the conversion.
// R16: low bits 3:0 read zero; writes to read-only bits ignored.
// R17: power-up value is 0x60A0.
module temp_sensor_config #(
	parameter int unsigned RATE0_CYCLES = cfg_pkg::RATE0_CYC,
	parameter int unsigned RATE1_CYCLES = cfg_pkg::RATE1_CYC,
	parameter int unsigned RATE2_CYCLES = cfg_pkg::RATE2_CYC,
	parameter int unsigned RATE3_CYCLES = cfg_pkg::RATE3_CYC
) (
	// system clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// link clock and byte strobes
	input wire logic LINK_CLK,
	input wire logic FRAME_START,
	input wire logic PTR_WR,
	input wire logic DATA_WR,
	input wire logic GCALL_WR,
	input wire logic RD_REQ,
	input wire logic [7:0] WR_BYTE,
	// read answer on the link clock
	output logic [7:0] RD_BYTE,
	output logic RD_HIT,
	// converter status
	input wire cfg_pkg::sense_t SENSE,
	// converter control
	output logic CONV_START,
	output logic CONV_ABORT,
	output logic SHUTDOWN,
	output logic IRQ_MODE,
	output logic WIDE_RANGE,
	output logic [1:0] RATE_SEL,
	output logic ACTIVE_LEVEL,
	output logic [1:0] FAULT_SEL,
	// status
	output logic OVER_TEMP,
	output logic COMPARATOR_FLAG,
	output logic [15:0] CONFIG_WORD
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		// stored word and idle flag
		logic [15:0] cfg;
		logic idle;
		// write crossing from the link side
		logic wr_s1;
		logic wr_s2;
		logic wr_seen;
		// general call crossing
		logic gc_s1;
		logic gc_s2;
		logic gc_seen;
		// read view crossing to the link side
		logic [15:0] snap;
		logic sreq;
		logic sack_s1;
		logic sack_s2;
		// conversion pacing
		logic [cfg_pkg::TIMER_W-1:0] timer;
		logic start;
		logic abort;
		// word as the host reads it
		logic [15:0] view;
	} sys_state_t;

	sys_state_t s_q;
	sys_state_t s_d;

	logic wr_req_tgl;
	cfg_pkg::wr_word_t wr_word;
	logic gc_tgl;
	logic snap_ack_tgl;
	logic over_temp;
	logic cmp_flag;
	logic gc_event;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [15:0] lane_mask(input logic [1:0] lanes);
		logic [15:0] m;
		m = 16'h0000;
		if (lanes[1]) begin
			m = m | cfg_pkg::CFG_HI_LANE;
		end
		if (lanes[0]) begin
			m = m | cfg_pkg::CFG_LO_LANE;
		end
		lane_mask = m & cfg_pkg::CFG_WR_MASK;
	endfunction

	function automatic logic [cfg_pkg::TIMER_W-1:0] rate_period(
			input logic [1:0] sel);
		case (sel)
			2'h0: rate_period = cfg_pkg::TIMER_W'(RATE0_CYCLES - 1);
			2'h1: rate_period = cfg_pkg::TIMER_W'(RATE1_CYCLES - 1);
			2'h2: rate_period = cfg_pkg::TIMER_W'(RATE2_CYCLES - 1);
			default: rate_period = cfg_pkg::TIMER_W'(RATE3_CYCLES - 1);
		endcase
	endfunction

	// ****************************************
	// link side
	// ****************************************
	link_port u_link (
		.clk(LINK_CLK),
		.rst_raw(RST),
		.frame_start(FRAME_START),
		.ptr_wr(PTR_WR),
		.data_wr(DATA_WR),
		.gcall_wr(GCALL_WR),
		.rd_req(RD_REQ),
		.wr_byte(WR_BYTE),
		.rd_byte(RD_BYTE),
		.rd_hit(RD_HIT),
		.wr_req_tgl(wr_req_tgl),
		.wr_word(wr_word),
		.wr_ack_tgl(s_q.wr_seen),
		.gc_tgl(gc_tgl),
		.snap_req_tgl(s_q.sreq),
		.snap_word(s_q.snap),
		.snap_ack_tgl(snap_ack_tgl)
	);

	// ****************************************
	// comparator status
	// ****************************************
	assign gc_event = (s_q.gc_s2 != s_q.gc_seen);

	// R12: mode bit not wired in
	fault_filter u_filter (
		.clk(CLOCK),
		.rst(RST),
		.clear(gc_event),
		.sample(SENSE.done),
		.above_high(SENSE.above_high),
		.below_low(SENSE.below_low),
		.fault_sel(s_q.cfg[cfg_pkg::FAULT_HI_BIT:cfg_pkg::FAULT_LO_BIT]),
		// next polarity, so flag and level switch on one edge
		.active_level(s_d.cfg[cfg_pkg::POL_BIT]),
		.over_temp(over_temp),
		.comparator_flag(cmp_flag)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic [15:0] m;
		m = 16'h0000;
		s_d = s_q;
		s_d.start = 1'b0;
		s_d.abort = 1'b0;

		// ****************************************
		// crossings
		// ****************************************
		// the first stages feed only the second stages
		s_d.wr_s1 = wr_req_tgl;
		s_d.wr_s2 = s_q.wr_s1;
		s_d.gc_s1 = gc_tgl;
		s_d.gc_s2 = s_q.gc_s1;
		s_d.sack_s1 = snap_ack_tgl;
		s_d.sack_s2 = s_q.sack_s1;

		// R3: idle flag from converter
		s_d.idle = ~SENSE.busy;

		if (s_q.wr_s2 != s_q.wr_seen) begin
			// R16: read-only bits masked
			m = lane_mask(wr_word.lanes);
			s_d.cfg = (s_q.cfg & ~m) | (wr_word.data & m);
			s_d.wr_seen = s_q.wr_s2;
		end

		// ****************************************
		// conversion pacing
		// ****************************************
		// conversion pacing; shutdown parks the timer
		if (s_q.cfg[cfg_pkg::SHDN_BIT]) begin
			// R8: shutdown stops conversions
			s_d.timer = '0;
		end else if (s_q.timer == '0) begin
			// R9: period from rate code
			s_d.start = 1'b1;
			s_d.timer = rate_period(
				s_q.cfg[cfg_pkg::RATE_HI_BIT:cfg_pkg::RATE_LO_BIT]);
		end else begin
			s_d.timer = s_q.timer - cfg_pkg::TIMER_W'(1);
		end

		// ****************************************
		// general call
		// ****************************************
		if (gc_event) begin
			// R15: defaults and abort
			s_d.gc_seen = s_q.gc_s2;
			s_d.cfg = cfg_pkg::CFG_RESET;
			s_d.idle = cfg_pkg::CFG_RESET[cfg_pkg::IDLE_BIT];
			s_d.timer = '0;
			s_d.start = 1'b0;
			s_d.abort = 1'b1;
		end

		// ****************************************
		// host view of the word
		// ****************************************
		// R4: resolution fixed
		s_d.view = 16'h0000;
		s_d.view[cfg_pkg::IDLE_BIT] = s_d.idle;
		s_d.view[cfg_pkg::RES_HI_BIT:cfg_pkg::RES_LO_BIT] =
			cfg_pkg::RES_FIXED;
		s_d.view[cfg_pkg::FAULT_HI_BIT:cfg_pkg::FAULT_LO_BIT] =
			s_d.cfg[cfg_pkg::FAULT_HI_BIT:cfg_pkg::FAULT_LO_BIT];
		s_d.view[cfg_pkg::POL_BIT] = s_d.cfg[cfg_pkg::POL_BIT];
		s_d.view[cfg_pkg::MODE_BIT] = s_d.cfg[cfg_pkg::MODE_BIT];
		s_d.view[cfg_pkg::SHDN_BIT] = s_d.cfg[cfg_pkg::SHDN_BIT];
		s_d.view[cfg_pkg::RATE_HI_BIT:cfg_pkg::RATE_LO_BIT] =
			s_d.cfg[cfg_pkg::RATE_HI_BIT:cfg_pkg::RATE_LO_BIT];
		// R10: status from the filter, not the stored word
		s_d.view[cfg_pkg::CMP_BIT] = cmp_flag;
		s_d.view[cfg_pkg::WIDE_BIT] = s_d.cfg[cfg_pkg::WIDE_BIT];
		// R16: reserved bits read zero
		s_d.view[cfg_pkg::WIDE_BIT-1:0] = cfg_pkg::LOW_NIBBLE_ZERO;

		// ****************************************
		// read view crossing
		// ****************************************
		// word crossing: refresh only when the last one was taken
		if (s_q.sreq == s_q.sack_s2 && s_q.view != s_q.snap) begin
			s_d.snap = s_q.view;
			s_d.sreq = ~s_q.sreq;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			// R17: power-up value
			s_q <= '{
				cfg: cfg_pkg::CFG_RESET,
				idle: cfg_pkg::CFG_RESET[cfg_pkg::IDLE_BIT],
				wr_s1: 1'b0,
				wr_s2: 1'b0,
				wr_seen: 1'b0,
				gc_s1: 1'b0,
				gc_s2: 1'b0,
				gc_seen: 1'b0,
				snap: cfg_pkg::CFG_RESET,
				sreq: 1'b0,
				sack_s1: 1'b0,
				sack_s2: 1'b0,
				timer: '0,
				start: 1'b0,
				abort: 1'b0,
				view: cfg_pkg::CFG_RESET
			};
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign CONV_START = s_q.start;
	assign CONV_ABORT = s_q.abort;
	// R8: shutdown select
	assign SHUTDOWN = s_q.cfg[cfg_pkg::SHDN_BIT];
	// R7: mode select
	assign IRQ_MODE = s_q.cfg[cfg_pkg::MODE_BIT];
	// R13: wide format select
	assign WIDE_RANGE = s_q.cfg[cfg_pkg::WIDE_BIT];
	assign RATE_SEL = s_q.cfg[cfg_pkg::RATE_HI_BIT:cfg_pkg::RATE_LO_BIT];
	// R6: alert active level
	assign ACTIVE_LEVEL = s_q.cfg[cfg_pkg::POL_BIT];
	// R5: fault count code
	assign FAULT_SEL = s_q.cfg[cfg_pkg::FAULT_HI_BIT:cfg_pkg::FAULT_LO_BIT];
	assign OVER_TEMP = over_temp;
	assign COMPARATOR_FLAG = cmp_flag;
	// R1: full word view
	assign CONFIG_WORD = s_q.view;

endmodule // temp_sensor_config

// *** tb/cfg_sva.sv ***
// assertions on the sensor configuration register ports
module cfg_sva (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// watched ports
	input wire cfg_pkg::sense_t SENSE,
	input wire logic CONV_START,
	input wire logic CONV_ABORT,
	input wire logic SHUTDOWN,
	input wire logic IRQ_MODE,
	input wire logic WIDE_RANGE,
	input wire logic [1:0] RATE_SEL,
	input wire logic ACTIVE_LEVEL,
	input wire logic [1:0] FAULT_SEL,
	input wire logic OVER_TEMP,
	input wire logic COMPARATOR_FLAG,
	input wire logic [15:0] CONFIG_WORD
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);
	// ****************************************
	// properties
	// ****************************************
	a_reset_word: assert property (disable iff (1'b0)
		RST |=> CONFIG_WORD == cfg_pkg::CFG_RESET) else $error("bad reset word");
	a_res_fixed: assert property (CONFIG_WORD[14:13] == 2'h3)
		else $error("resolution bits not 11");
	a_low_zero: assert property (CONFIG_WORD[3:0] == 4'h0)
		else $error("low nibble not zero");
	a_cmp_level: assert property (COMPARATOR_FLAG ==
		~(OVER_TEMP ^ ACTIVE_LEVEL)) else $error("comparator flag level");
	a_field_outs: assert property (SHUTDOWN == CONFIG_WORD[8] &&
		IRQ_MODE == CONFIG_WORD[9] && WIDE_RANGE == CONFIG_WORD[4] &&
		RATE_SEL == CONFIG_WORD[7:6] && ACTIVE_LEVEL == CONFIG_WORD[10] &&
		FAULT_SEL == CONFIG_WORD[12:11]) else $error("field outputs differ");
	a_shdn_quiet: assert property (SHUTDOWN && $past(SHUTDOWN) |-> !CONV_START)
		else $error("start while shut down");
	a_idle_rise: assert property ($fell(SENSE.busy) |-> ##[1:3] CONFIG_WORD[15])
		else $error("idle flag not set");
	a_idle_fall: assert property ($rose(SENSE.busy) |-> ##[1:3] !CONFIG_WORD[15])
		else $error("idle flag not cleared");
	a_abort_dflt: assert property (CONV_ABORT |=> !CONV_ABORT ##[0:3]
		CONFIG_WORD[14:0] == cfg_pkg::CFG_RESET[14:0]) else $error("abort");
	c_abort: cover property (CONV_ABORT);
	c_over: cover property (OVER_TEMP && ACTIVE_LEVEL);
	c_shdn: cover property (SHUTDOWN ##1 SHUTDOWN);
endmodule // cfg_sva

bind temp_sensor_config cfg_sva u_sva (.CLOCK(CLOCK), .RST(RST), .SENSE(SENSE),
	.CONV_START(CONV_START), .CONV_ABORT(CONV_ABORT), .SHUTDOWN(SHUTDOWN),
	.IRQ_MODE(IRQ_MODE), .WIDE_RANGE(WIDE_RANGE), .RATE_SEL(RATE_SEL),
	.ACTIVE_LEVEL(ACTIVE_LEVEL), .FAULT_SEL(FAULT_SEL), .OVER_TEMP(OVER_TEMP),
	.COMPARATOR_FLAG(COMPARATOR_FLAG), .CONFIG_WORD(CONFIG_WORD));

// *** tb/link_host.sv ***
// model of the two-wire host behind the link byte strobes
module link_host (
	// link clock
	input wire logic link_clk,
	// strobes to the register
	output logic frame_start,
	output logic ptr_wr,
	output logic data_wr,
	output logic gcall_wr,
	output logic rd_req,
	output logic [7:0] wr_byte,
	// read answer
	input wire logic [7:0] rd_byte,
	input wire logic rd_hit
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{frame_start, ptr_wr, data_wr, gcall_wr, rd_req} = 5'h00;
		wr_byte = 8'h00;
	end
	// one strobe; the idle bus shows the inverse so stale bytes never match
	task automatic send(input logic [1:0] kind, input logic [7:0] b);
		@(posedge link_clk);
		wr_byte <= b;
		ptr_wr <= kind == 2'h0;
		data_wr <= kind == 2'h1;
		gcall_wr <= kind == 2'h2;
		@(posedge link_clk);
		{ptr_wr, data_wr, gcall_wr} <= 3'h0;
		wr_byte <= ~b;
	endtask
	task automatic write_word(input logic [15:0] w);
		send(2'h0, cfg_pkg::PTR_CONFIG);
		send(2'h1, w[15:8]);
		send(2'h1, w[7:0]);
	endtask
	// again: reuse the stored pointer, only restart the byte index
	task automatic read_word(input logic again, output logic [15:0] w);
		if (again) begin
			@(posedge link_clk);
			frame_start <= 1'b1;
			@(posedge link_clk);
			frame_start <= 1'b0;
		end else begin
			send(2'h0, cfg_pkg::PTR_CONFIG);
		end
		#1 w[15:8] = rd_byte;
		@(posedge link_clk);
		rd_req <= 1'b1;
		@(posedge link_clk);
		rd_req <= 1'b0;
		#1 w[7:0] = rd_byte;
	endtask
endmodule // link_host

// *** tb/tb.sv ***
// self-checking bench for the sensor configuration register
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PER [4] = '{400, 200, 100, 50};
	localparam int FN [4] = '{1, 2, 4, 6};
	logic CLOCK = 1'b0;
	logic RST = 1'b1;
	logic LINK_CLK = 1'b0;
	logic FRAME_START, PTR_WR, DATA_WR, GCALL_WR, RD_REQ, RD_HIT;
	logic [7:0] WR_BYTE, RD_BYTE;
	cfg_pkg::sense_t SENSE = '0;
	logic CONV_START, CONV_ABORT, SHUTDOWN, IRQ_MODE, WIDE_RANGE;
	logic ACTIVE_LEVEL, OVER_TEMP, COMPARATOR_FLAG;
	logic [1:0] RATE_SEL, FAULT_SEL;
	logic [15:0] CONFIG_WORD, w;
	logic hot = 1'b0;
	logic cold = 1'b0;
	logic [2:0] cnt = 3'h0;
	int error_cnt = 0;
	int num_checks = 0;
	int cyc = 0;
	int n;
	always #10 CLOCK = ~CLOCK;
	// link clock off phase with the system clock
	initial #7 forever #15 LINK_CLK = ~LINK_CLK;
	temp_sensor_config #(.RATE0_CYCLES(PER[0]), .RATE1_CYCLES(PER[1]),
		.RATE2_CYCLES(PER[2]), .RATE3_CYCLES(PER[3])) u_dut (
		.CLOCK(CLOCK), .RST(RST), .LINK_CLK(LINK_CLK),
		.FRAME_START(FRAME_START), .PTR_WR(PTR_WR), .DATA_WR(DATA_WR),
		.GCALL_WR(GCALL_WR), .RD_REQ(RD_REQ), .WR_BYTE(WR_BYTE),
		.RD_BYTE(RD_BYTE), .RD_HIT(RD_HIT), .SENSE(SENSE),
		.CONV_START(CONV_START), .CONV_ABORT(CONV_ABORT), .SHUTDOWN(SHUTDOWN),
		.IRQ_MODE(IRQ_MODE), .WIDE_RANGE(WIDE_RANGE), .RATE_SEL(RATE_SEL),
		.ACTIVE_LEVEL(ACTIVE_LEVEL), .FAULT_SEL(FAULT_SEL),
		.OVER_TEMP(OVER_TEMP), .COMPARATOR_FLAG(COMPARATOR_FLAG),
		.CONFIG_WORD(CONFIG_WORD));
	link_host u_host (.link_clk(LINK_CLK), .frame_start(FRAME_START),
		.ptr_wr(PTR_WR), .data_wr(DATA_WR), .gcall_wr(GCALL_WR),
		.rd_req(RD_REQ), .wr_byte(WR_BYTE), .rd_byte(RD_BYTE),
		.rd_hit(RD_HIT));
	// ****************************************
	// converter stand-in: four cycles per conversion
	// ****************************************
	always @(posedge CLOCK) begin
		SENSE.done <= 1'b0;
		if (RST || CONV_ABORT) begin
			SENSE <= '0;
		end else if (CONV_START) begin
			SENSE.busy <= 1'b1;
			cnt <= 3'h4;
		end else if (SENSE.busy) begin
			cnt <= cnt - 3'h1;
			if (cnt == 3'h1) begin
				SENSE <= {1'b0, 1'b1, hot, cold};
			end
		end
	end
	always @(posedge CLOCK) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			close_out();
		end
	end
	// ****************************************
	// helpers
	// ****************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge CLOCK);
		#1;
	endtask
	task automatic wait_for(input int which);
		for (int i = 0; i < 1000; i++) begin
			if ((which == 0 ? CONV_START : which == 1 ? SENSE.done :
				CONV_ABORT) === 1'b1) break;
			tick(1);
		end
	endtask
	task automatic wr(input logic [15:0] v);
		u_host.write_word(v);
		tick(20);
	endtask
	task automatic close_out;
		if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// ****************************************
	// tests
	// ****************************************
	initial begin
		repeat (7) @(posedge CLOCK);
		RST <= 1'b0;
		tick(10);
		check(CONFIG_WORD & 16'h7FFF, cfg_pkg::CFG_RESET);
		u_host.read_word(1'b0, w);
		check(w & 16'h7FFF, cfg_pkg::CFG_RESET);
		check({15'h0, RD_HIT}, 16'h0001);
		wr(16'hFFFF);
		check(CONFIG_WORD, 16'hFFD0);
		n = 0;
		repeat (200) begin
			tick(1);
			n += int'(CONV_START === 1'b1);
		end
		check(16'(n), 16'h0000);
		u_host.read_word(1'b1, w);
		check(w, 16'hFFD0);
		wr(16'h0000);
		check(CONFIG_WORD & 16'h7FFF, 16'h6020);
		u_host.send(2'h0, 8'h02);
		u_host.send(2'h1, 8'h00);
		u_host.send(2'h1, 8'hFF);
		u_host.send(2'h2, 8'h05);
		tick(20);
		check(CONFIG_WORD & 16'h7FFF, 16'h6020);
		check({15'h0, RD_HIT}, 16'h0000);
		wr(16'h1F50);
		u_host.send(2'h2, cfg_pkg::GCALL_RESET_CODE);
		wait_for(2);
		check({15'h0, CONV_ABORT}, 16'h0001);
		tick(10);
		check(CONFIG_WORD & 16'h7FFF, cfg_pkg::CFG_RESET);
		for (int r = 0; r < 4; r++) begin
			wr({8'h00, r[1:0], 6'h00});
			wait_for(0);
			n = 0;
			do begin
				tick(1);
				n++;
			end while (CONV_START !== 1'b1 && n < 1000);
			check(16'(n), 16'(PER[r]));
		end
		// pol follows k[0] and mode k[1], so every pairing is seen
		for (int k = 0; k < 4; k++) begin
			wr({3'h0, k[1:0], k[0], k[1], 1'b0, 8'hC0});
			hot = 1'b1;
			cold = 1'b0;
			// a done launched before the change must not count
			tick(1);
			repeat (FN[k] - 1) begin
				wait_for(1);
				tick(1);
				check({15'h0, OVER_TEMP}, 16'h0000);
			end
			wait_for(1);
			tick(2);
			check({13'h0, OVER_TEMP, COMPARATOR_FLAG, CONFIG_WORD[5]},
				{13'h0, 1'b1, k[0], k[0]});
			hot = 1'b0;
			cold = 1'b1;
			repeat (FN[k]) begin
				wait_for(1);
				tick(1);
			end
			tick(1);
			check({13'h0, OVER_TEMP, COMPARATOR_FLAG, CONFIG_WORD[5]},
				{13'h0, 1'b0, ~k[0], ~k[0]});
		end
		close_out();
	end
endmodule // tb
